// ===== hw/wahc_pkg.sv
package wahc_pkg;
    localparam int WAHC_REG_W = 64;
    localparam logic [63:0] WAHC_RESET_VAL = 64'h0000_0000_0000_0000;
    // Writable fields; everything else is reserved and reads zero
    localparam logic [63:0] WAHC_MASK_SPLIT = 64'h0000_0000_0000_3333;
    localparam logic [63:0] WAHC_MASK_SINGLE = 64'h0000_0000_0000_0303;
    localparam int WAHC_UPPER_VAL1 = 13;
    localparam int WAHC_UPPER_VAL0 = 12;
    localparam int WAHC_LOWER_VAL1 = 9;
    localparam int WAHC_LOWER_VAL0 = 8;
    localparam int WAHC_UPPER_EN1 = 5;
    localparam int WAHC_UPPER_EN0 = 4;
    localparam int WAHC_LOWER_EN1 = 1;
    localparam int WAHC_LOWER_EN0 = 0;
    // System register encodings
    localparam logic [1:0] WAHC_OP0_SYS = 2'h3;
    localparam logic [3:0] WAHC_CRN_IMP = 4'hF;
    localparam logic [3:0] WAHC_CRM_WALK = 4'h7;
    localparam logic [2:0] WAHC_OP1_GUEST = 3'h0;
    localparam logic [2:0] WAHC_OP1_HYP = 3'h4;
    localparam logic [2:0] WAHC_OP1_ALIAS = 3'h5;
    localparam logic [2:0] WAHC_OP1_MON = 3'h6;
    localparam logic [2:0] WAHC_OP2_CTRL = 3'h0;
    localparam logic [2:0] WAHC_OP2_STAGE2 = 3'h1;
    // Exception levels
    localparam logic [1:0] WAHC_EL1 = 2'h1;
    localparam logic [1:0] WAHC_EL2 = 2'h2;
    localparam logic [1:0] WAHC_EL3 = 2'h3;
    // Requester register map, byte addresses
    localparam logic [7:0] WAHC_ADDR_ACCESS = 8'h00;
    localparam logic [7:0] WAHC_ADDR_WDATA_LO = 8'h04;
    localparam logic [7:0] WAHC_ADDR_WDATA_HI = 8'h08;
    localparam logic [7:0] WAHC_ADDR_RDATA_LO = 8'h0C;
    localparam logic [7:0] WAHC_ADDR_RDATA_HI = 8'h10;
    localparam logic [7:0] WAHC_ADDR_STATUS = 8'h14;
    localparam logic [7:0] WAHC_ADDR_WALK = 8'h18;
    // Access register fields
    localparam int WAHC_ACC_OP1_LSB = 0;
    localparam int WAHC_ACC_OP2_LSB = 3;
    localparam int WAHC_ACC_CRN_LSB = 6;
    localparam int WAHC_ACC_CRM_LSB = 10;
    localparam int WAHC_ACC_OP0_LSB = 14;
    localparam int WAHC_ACC_WRITE = 16;
    localparam int WAHC_ACC_EL_LSB = 17;
    localparam int WAHC_ACC_NS = 19;
    localparam int WAHC_ACC_E2H = 20;
    localparam int WAHC_ACC_TRAP = 21;
    // Walk register fields
    localparam int WAHC_WALK_REGIME_LSB = 0;
    localparam int WAHC_WALK_UPPER = 2;
    localparam int WAHC_WALK_S2EN = 3;
    localparam int WAHC_WALK_NS = 4;
    // Status register fields
    localparam int WAHC_ST_DONE = 0;
    localparam int WAHC_ST_UNDEF = 1;
    localparam int WAHC_ST_TRAP = 2;
    localparam int WAHC_ST_WALK_DONE = 3;
    localparam int WAHC_ST_HINT_LSB = 4;

    typedef enum logic [1:0]
    {
        WAHC_RG_HYP,
        WAHC_RG_MON,
        WAHC_RG_GUEST_S1,
        WAHC_RG_GUEST_S2
    } wahc_regime_t;
endpackage : wahc_pkg

// ===== hw/wahc_if.sv
`timescale 1ns/1ns
interface wahc_if;
    import wahc_pkg::*;
    logic acc_req;
    logic acc_write;
    logic [1:0] acc_op0;
    logic [2:0] acc_op1;
    logic [3:0] acc_crn;
    logic [3:0] acc_crm;
    logic [2:0] acc_op2;
    logic [1:0] acc_el;
    logic [63:0] acc_wdata;
    logic ctl_host_ext;
    logic ctl_nonsecure;
    logic ctl_guest_trap;
    logic acc_ack;
    logic [63:0] acc_rdata;
    logic acc_undef;
    logic acc_trap;
    logic walk_req;
    wahc_regime_t walk_regime;
    logic walk_upper;
    logic walk_stage2_en;
    logic walk_nonsecure;
    logic walk_ack;
    logic [1:0] walk_hint;

    modport dev
    (
        input acc_req, acc_write, acc_op0, acc_op1, acc_crn, acc_crm, acc_op2, acc_el,
        input acc_wdata, ctl_host_ext, ctl_nonsecure, ctl_guest_trap,
        input walk_req, walk_regime, walk_upper, walk_stage2_en, walk_nonsecure,
        output acc_ack, acc_rdata, acc_undef, acc_trap, walk_ack, walk_hint
    );
    modport req
    (
        output acc_req, acc_write, acc_op0, acc_op1, acc_crn, acc_crm, acc_op2, acc_el,
        output acc_wdata, ctl_host_ext, ctl_nonsecure, ctl_guest_trap,
        output walk_req, walk_regime, walk_upper, walk_stage2_en, walk_nonsecure,
        input acc_ack, acc_rdata, acc_undef, acc_trap, walk_ack, walk_hint
    );
endinterface : wahc_if

// ===== hw/wahc_device.sv
`timescale 1ns/1ns
module wahc_device
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    wahc_if.dev bus,
    output logic [63:0] o_ctrl_hypervisor,
    output logic [63:0] o_ctrl_monitor,
    output logic [63:0] o_ctrl_stage2,
    output logic [63:0] o_ctrl_guest
);
    import wahc_pkg::*;

    // Split layout: separate field pairs per table base
    function automatic logic [1:0] wahc_hint_split(input logic [63:0] r, input logic upper);
        logic [1:0] h;
        h = 2'h0;
        if (upper)
        begin
            h[1] = r[WAHC_UPPER_VAL1] & r[WAHC_UPPER_EN1];
            h[0] = r[WAHC_UPPER_VAL0] & r[WAHC_UPPER_EN0];
        end
        else
        begin
            h[1] = r[WAHC_LOWER_VAL1] & r[WAHC_LOWER_EN1];
            h[0] = r[WAHC_LOWER_VAL0] & r[WAHC_LOWER_EN0];
        end
        return h;
    endfunction : wahc_hint_split

    // Single layout shares the lower field positions
    function automatic logic [1:0] wahc_hint_single(input logic [63:0] r);
        logic [1:0] h;
        h = 2'h0;
        h[1] = r[WAHC_LOWER_VAL1] & r[WAHC_LOWER_EN1];
        h[0] = r[WAHC_LOWER_VAL0] & r[WAHC_LOWER_EN0];
        return h;
    endfunction : wahc_hint_single

    logic [63:0] hyp_reg;
    logic [63:0] hyp_next;
    logic [63:0] mon_reg;
    logic [63:0] mon_next;
    logic [63:0] s2_reg;
    logic [63:0] s2_next;
    logic [63:0] guest_reg;
    logic [63:0] guest_next;
    logic ack_reg;
    logic undef_reg;
    logic trap_reg;
    logic [63:0] rdata_reg;
    logic [63:0] rdata_next;
    logic walk_ack_reg;
    logic [1:0] hint_reg;
    logic [1:0] hint_next;

    wire enc_common = (bus.acc_op0 == WAHC_OP0_SYS) && (bus.acc_crn == WAHC_CRN_IMP)
        && (bus.acc_crm == WAHC_CRM_WALK);
    wire hit_hyp = enc_common && (bus.acc_op1 == WAHC_OP1_HYP)
        && (bus.acc_op2 == WAHC_OP2_CTRL);
    wire hit_s2 = enc_common && (bus.acc_op1 == WAHC_OP1_HYP)
        && (bus.acc_op2 == WAHC_OP2_STAGE2);
    wire hit_mon = enc_common && (bus.acc_op1 == WAHC_OP1_MON)
        && (bus.acc_op2 == WAHC_OP2_CTRL);
    wire hit_guest = enc_common && (bus.acc_op1 == WAHC_OP1_GUEST)
        && (bus.acc_op2 == WAHC_OP2_CTRL);
    wire hit_alias = enc_common && (bus.acc_op1 == WAHC_OP1_ALIAS)
        && (bus.acc_op2 == WAHC_OP2_CTRL);

    wire el_ge1 = (bus.acc_el >= WAHC_EL1);
    wire el_ge2 = (bus.acc_el >= WAHC_EL2);
    wire el_is3 = (bus.acc_el == WAHC_EL3);
    // Host extension at level 2 turns the guest encoding into the hypervisor one
    wire guest_remap = hit_guest && (bus.acc_el == WAHC_EL2) && bus.ctl_host_ext;
    wire sel_hyp = (hit_hyp && el_ge2) || guest_remap;
    wire sel_s2 = hit_s2 && el_ge2;
    wire sel_mon = hit_mon && el_is3;
    wire sel_guest_direct = hit_guest && el_ge1 && !guest_remap;
    wire sel_alias = hit_alias && el_ge2 && bus.ctl_host_ext;
    wire sel_guest = sel_guest_direct || sel_alias;
    wire sel_any = sel_hyp || sel_s2 || sel_mon || sel_guest;
    // Lower levels, unknown encodings and alias without host extension
    wire acc_undef = bus.acc_req && !sel_any;
    wire acc_trap = bus.acc_req && sel_guest && bus.ctl_guest_trap;
    wire acc_wr_ok = bus.acc_req && bus.acc_write && !acc_undef && !acc_trap;

    // Reserved bits never stored, so they read back as zero
    wire [63:0] wdata_split = bus.acc_wdata & WAHC_MASK_SPLIT;
    wire [63:0] wdata_single = bus.acc_wdata & WAHC_MASK_SINGLE;

    assign hyp_next = (acc_wr_ok && sel_hyp) ? wdata_split : hyp_reg;
    assign s2_next = (acc_wr_ok && sel_s2) ? wdata_single : s2_reg;
    assign mon_next = (acc_wr_ok && sel_mon) ? wdata_single : mon_reg;
    assign guest_next = (acc_wr_ok && sel_guest) ? wdata_split : guest_reg;

    // Refused reads return zero so no state leaks on a trap
    always_comb
    begin
        rdata_next = WAHC_RESET_VAL;
        if (bus.acc_req && !bus.acc_write && !acc_undef && !acc_trap)
        begin
            if (sel_hyp)
            begin
                rdata_next = hyp_reg;
            end
            else if (sel_s2)
            begin
                rdata_next = s2_reg;
            end
            else if (sel_mon)
            begin
                rdata_next = mon_reg;
            end
            else
            begin
                rdata_next = guest_reg;
            end
        end
    end

    // Walk hint selection by regime, stage and table base
    always_comb
    begin
        hint_next = 2'h0;
        unique case (bus.walk_regime)
            WAHC_RG_HYP:
            begin
                hint_next = wahc_hint_split(hyp_reg, bus.walk_upper);
            end
            WAHC_RG_MON:
            begin
                hint_next = wahc_hint_single(mon_reg);
            end
            WAHC_RG_GUEST_S1:
            begin
                hint_next = wahc_hint_split(guest_reg, bus.walk_upper);
            end
            WAHC_RG_GUEST_S2:
            begin
                if (bus.walk_stage2_en && bus.walk_nonsecure)
                begin
                    hint_next = wahc_hint_single(s2_reg);
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hyp_reg <= WAHC_RESET_VAL;
            s2_reg <= WAHC_RESET_VAL;
            mon_reg <= WAHC_RESET_VAL;
            guest_reg <= WAHC_RESET_VAL;
        end
        else
        begin
            hyp_reg <= hyp_next;
            s2_reg <= s2_next;
            mon_reg <= mon_next;
            guest_reg <= guest_next;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ack_reg <= 1'b0;
            undef_reg <= 1'b0;
            trap_reg <= 1'b0;
            rdata_reg <= WAHC_RESET_VAL;
        end
        else
        begin
            ack_reg <= bus.acc_req;
            undef_reg <= acc_undef;
            trap_reg <= acc_trap;
            rdata_reg <= rdata_next;
        end
    end

    // Hint is held until the next walk so the memory side may sample late
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            walk_ack_reg <= 1'b0;
            hint_reg <= 2'h0;
        end
        else
        begin
            walk_ack_reg <= bus.walk_req;
            if (bus.walk_req)
            begin
                hint_reg <= hint_next;
            end
        end
    end

    assign bus.acc_ack = ack_reg;
    assign bus.acc_undef = undef_reg;
    assign bus.acc_trap = trap_reg;
    assign bus.acc_rdata = rdata_reg;
    assign bus.walk_ack = walk_ack_reg;
    assign bus.walk_hint = hint_reg;
    assign o_ctrl_hypervisor = hyp_reg;
    assign o_ctrl_monitor = mon_reg;
    assign o_ctrl_stage2 = s2_reg;
    assign o_ctrl_guest = guest_reg;
endmodule : wahc_device

// ===== hw/wahc_requester.sv
`timescale 1ns/1ns
module wahc_requester
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    wahc_if.req bus
);
    import wahc_pkg::*;

    logic [31:0] access_reg;
    logic [63:0] wdata_reg;
    logic [63:0] rdata_reg;
    logic [4:0] walk_reg;
    logic acc_req_reg;
    logic walk_req_reg;
    logic done_reg;
    logic undef_reg;
    logic trap_reg;
    logic walk_done_reg;
    logic [1:0] hint_reg;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;

    wire wr_access = i_wr && (i_addr == WAHC_ADDR_ACCESS);
    wire wr_wlo = i_wr && (i_addr == WAHC_ADDR_WDATA_LO);
    wire wr_whi = i_wr && (i_addr == WAHC_ADDR_WDATA_HI);
    wire wr_status = i_wr && (i_addr == WAHC_ADDR_STATUS);
    wire wr_walk = i_wr && (i_addr == WAHC_ADDR_WALK);
    // Set wins over a write-one-to-clear in the same cycle
    wire done_next = bus.acc_ack || (done_reg && !(wr_status && i_wdata[WAHC_ST_DONE]));
    wire walk_done_next = bus.walk_ack
        || (walk_done_reg && !(wr_status && i_wdata[WAHC_ST_WALK_DONE]));
    wire [31:0] status_word = {26'h0, hint_reg, walk_done_reg, trap_reg, undef_reg, done_reg};

    always_comb
    begin
        rd_next = 32'h0;
        unique case (i_addr)
            WAHC_ADDR_ACCESS: rd_next = access_reg;
            WAHC_ADDR_WDATA_LO: rd_next = wdata_reg[31:0];
            WAHC_ADDR_WDATA_HI: rd_next = wdata_reg[63:32];
            WAHC_ADDR_RDATA_LO: rd_next = rdata_reg[31:0];
            WAHC_ADDR_RDATA_HI: rd_next = rdata_reg[63:32];
            WAHC_ADDR_STATUS: rd_next = status_word;
            WAHC_ADDR_WALK: rd_next = {27'h0, walk_reg};
            default: rd_next = 32'h0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            access_reg <= 32'h0;
            wdata_reg <= 64'h0;
            walk_reg <= 5'h0;
            acc_req_reg <= 1'b0;
            walk_req_reg <= 1'b0;
            rd_reg <= 32'h0;
        end
        else
        begin
            if (wr_access)
            begin
                access_reg <= i_wdata;
            end
            if (wr_wlo)
            begin
                wdata_reg[31:0] <= i_wdata;
            end
            if (wr_whi)
            begin
                wdata_reg[63:32] <= i_wdata;
            end
            if (wr_walk)
            begin
                walk_reg <= i_wdata[4:0];
            end
            acc_req_reg <= wr_access;
            walk_req_reg <= wr_walk;
            rd_reg <= i_rd ? rd_next : 32'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_reg <= 64'h0;
            done_reg <= 1'b0;
            undef_reg <= 1'b0;
            trap_reg <= 1'b0;
            walk_done_reg <= 1'b0;
            hint_reg <= 2'h0;
        end
        else
        begin
            done_reg <= done_next;
            walk_done_reg <= walk_done_next;
            if (bus.acc_ack)
            begin
                rdata_reg <= bus.acc_rdata;
                undef_reg <= bus.acc_undef;
                trap_reg <= bus.acc_trap;
            end
            if (bus.walk_ack)
            begin
                hint_reg <= bus.walk_hint;
            end
        end
    end

    assign o_rdata = rd_reg;
    assign bus.acc_req = acc_req_reg;
    // Encoding fields, per-access context and data come straight from registers
    assign bus.acc_op1 = access_reg[WAHC_ACC_OP1_LSB +: 3];
    assign bus.acc_op2 = access_reg[WAHC_ACC_OP2_LSB +: 3];
    assign bus.acc_crn = access_reg[WAHC_ACC_CRN_LSB +: 4];
    assign bus.acc_crm = access_reg[WAHC_ACC_CRM_LSB +: 4];
    assign bus.acc_op0 = access_reg[WAHC_ACC_OP0_LSB +: 2];
    assign bus.acc_write = access_reg[WAHC_ACC_WRITE];
    assign bus.acc_el = access_reg[WAHC_ACC_EL_LSB +: 2];
    assign bus.ctl_nonsecure = access_reg[WAHC_ACC_NS];
    assign bus.ctl_host_ext = access_reg[WAHC_ACC_E2H];
    assign bus.ctl_guest_trap = access_reg[WAHC_ACC_TRAP];
    assign bus.acc_wdata = wdata_reg;
    assign bus.walk_req = walk_req_reg;
    assign bus.walk_regime = wahc_regime_t'(walk_reg[WAHC_WALK_REGIME_LSB +: 2]);
    assign bus.walk_upper = walk_reg[WAHC_WALK_UPPER];
    assign bus.walk_stage2_en = walk_reg[WAHC_WALK_S2EN];
    assign bus.walk_nonsecure = walk_reg[WAHC_WALK_NS];
endmodule : wahc_requester

// ===== testbench/wahc_properties.sv
`timescale 1ns/1ns
module wahc_properties
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic acc_req,
    input wire logic [1:0] acc_op0,
    input wire logic [2:0] acc_op1,
    input wire logic [3:0] acc_crn,
    input wire logic [3:0] acc_crm,
    input wire logic [2:0] acc_op2,
    input wire logic [1:0] acc_el,
    input wire logic ctl_host_ext,
    input wire logic ctl_guest_trap,
    input wire logic acc_ack,
    input wire logic [63:0] acc_rdata,
    input wire logic acc_undef,
    input wire logic acc_trap,
    input wire logic walk_req,
    input wire wahc_pkg::wahc_regime_t walk_regime,
    input wire logic walk_stage2_en,
    input wire logic walk_nonsecure,
    input wire logic walk_ack,
    input wire logic [1:0] walk_hint
);
    import wahc_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    wire logic enc_sel = acc_op0 == WAHC_OP0_SYS && acc_crn == WAHC_CRN_IMP
        && acc_crm == WAHC_CRM_WALK;
    wire logic alias_sel = enc_sel && acc_op1 == WAHC_OP1_ALIAS && acc_op2 == WAHC_OP2_CTRL;
    wire logic mon_sel = enc_sel && acc_op1 == WAHC_OP1_MON && acc_op2 == WAHC_OP2_CTRL;
    // Both hypervisor and stage2 controls share op1
    wire logic hyp_sel = enc_sel && acc_op1 == WAHC_OP1_HYP && acc_op2 <= WAHC_OP2_STAGE2;

    a_ack_next: assert property (acc_req |=> acc_ack)
        else $error("access not answered next cycle");
    a_ack_cause: assert property (acc_ack |-> $past(acc_req))
        else $error("answer without request");
    a_reserved_zero: assert property (acc_ack
        |-> (acc_rdata & ~WAHC_MASK_SPLIT) == 64'h0)
        else $error("reserved bits read nonzero");
    a_refused_nodata: assert property ((acc_undef || acc_trap)
        |-> acc_rdata == 64'h0)
        else $error("refused access returned data");
    a_alias_undef: assert property (acc_req && alias_sel && !ctl_host_ext
        |=> acc_undef)
        else $error("alias without host extension not undefined");
    a_alias_trap: assert property (acc_req && alias_sel && ctl_host_ext
        && acc_el >= WAHC_EL2 && ctl_guest_trap |=> acc_trap && !acc_undef)
        else $error("alias access not trapped");
    a_mon_level: assert property (acc_req && mon_sel && acc_el != WAHC_EL3
        |=> acc_undef)
        else $error("monitor control reached below level 3");
    a_hyp_level: assert property (acc_req && hyp_sel && acc_el < WAHC_EL2
        |=> acc_undef)
        else $error("hypervisor control reached below level 2");
    a_walk_ack: assert property (walk_req |=> walk_ack)
        else $error("walk not answered next cycle");
    a_stage2_gate: assert property (walk_req && walk_regime == WAHC_RG_GUEST_S2
        && !(walk_stage2_en && walk_nonsecure) |=> walk_hint == 2'h0)
        else $error("stage2 hint given while stage2 off");
    a_hint_held: assert property (!walk_ack |-> $stable(walk_hint))
        else $error("hint changed without walk");
endmodule : wahc_properties

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
    import wahc_pkg::*;
    logic core_clk;
    logic arst_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [63:0] ctrl_hyp;
    logic [63:0] ctrl_mon;
    logic [63:0] ctrl_s2;
    logic [63:0] ctrl_guest;
    int miscompares;
    int checks;
    wahc_if bus_if();
    wahc_device i_wahc_device
    (
        .i_core_clk(core_clk),
        .i_arst_n(arst_n),
        .bus(bus_if.dev),
        .o_ctrl_hypervisor(ctrl_hyp),
        .o_ctrl_monitor(ctrl_mon),
        .o_ctrl_stage2(ctrl_s2),
        .o_ctrl_guest(ctrl_guest)
    );
    wahc_requester i_wahc_requester
    (
        .i_core_clk(core_clk),
        .i_arst_n(arst_n),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .bus(bus_if.req)
    );
    wahc_properties i_wahc_properties
    (
        .i_core_clk(core_clk),
        .i_arst_n(arst_n),
        .acc_req(bus_if.acc_req),
        .acc_op0(bus_if.acc_op0),
        .acc_op1(bus_if.acc_op1),
        .acc_crn(bus_if.acc_crn),
        .acc_crm(bus_if.acc_crm),
        .acc_op2(bus_if.acc_op2),
        .acc_el(bus_if.acc_el),
        .ctl_host_ext(bus_if.ctl_host_ext),
        .ctl_guest_trap(bus_if.ctl_guest_trap),
        .acc_ack(bus_if.acc_ack),
        .acc_rdata(bus_if.acc_rdata),
        .acc_undef(bus_if.acc_undef),
        .acc_trap(bus_if.acc_trap),
        .walk_req(bus_if.walk_req),
        .walk_regime(bus_if.walk_regime),
        .walk_stage2_en(bus_if.walk_stage2_en),
        .walk_nonsecure(bus_if.walk_nonsecure),
        .walk_ack(bus_if.walk_ack),
        .walk_hint(bus_if.walk_hint)
    );

    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge core_clk);
        wr <= 1'h0;
    endtask : bus_wr

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge core_clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask : bus_rd

    task automatic wait_st(input int b, output logic [31:0] s);
        for (int n = 0; n < 20; n++)
        begin
            bus_rd(WAHC_ADDR_STATUS, s);
            if (s[b] === 1'h1)
            begin
                return;
            end
        end
        miscompares++;
        $display("[ERR] %0t status wait ran out", $time);
        stop_test();
    endtask : wait_st

    // Flags are {trap, undef}; read data checked on reads only
    task automatic sys(input logic w, input logic [2:0] op1, input logic [2:0] op2,
        input logic [1:0] el, input logic e2h, input logic trp, input logic [63:0] d,
        input logic [1:0] flags, input logic [63:0] exp);
        logic [31:0] s;
        logic [31:0] lo;
        logic [31:0] hi;
        bus_wr(WAHC_ADDR_WDATA_LO, d[31:0]);
        bus_wr(WAHC_ADDR_WDATA_HI, d[63:32]);
        bus_wr(WAHC_ADDR_ACCESS, {10'h0, trp, e2h, 1'h1, el, w, WAHC_OP0_SYS, WAHC_CRM_WALK,
            WAHC_CRN_IMP, op2, op1});
        wait_st(WAHC_ST_DONE, s);
        chk({62'h0, s[WAHC_ST_TRAP], s[WAHC_ST_UNDEF]}, {62'h0, flags});
        bus_rd(WAHC_ADDR_RDATA_LO, lo);
        bus_rd(WAHC_ADDR_RDATA_HI, hi);
        if (w === 1'h0)
        begin
            chk({hi, lo}, exp);
        end
        bus_wr(WAHC_ADDR_STATUS, 32'h1);
    endtask : sys

    task automatic walk(input logic [1:0] rg, input logic up, input logic s2, input logic ns,
        input logic [1:0] exp);
        logic [31:0] s;
        bus_wr(WAHC_ADDR_WALK, {27'h0, ns, s2, up, rg});
        wait_st(WAHC_ST_WALK_DONE, s);
        chk({62'h0, s[5:4]}, {62'h0, exp});
        bus_wr(WAHC_ADDR_STATUS, 32'h8);
    endtask : walk

    function automatic logic [1:0] hint_of(input logic [63:0] v, input logic up);
        return up ? {v[13] & v[5], v[12] & v[4]} : {v[9] & v[1], v[8] & v[0]};
    endfunction : hint_of

    initial
    begin
        logic [31:0] r;
        logic [63:0] pats [5];
        pats = '{64'h3333, 64'h1111, 64'h3300, 64'h2022, 64'h0033};
        arst_n = 1'h0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'h0;
        rd = 1'h0;
        miscompares = 0;
        checks = 0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'h1;
        bus_rd(8'h40, r);
        chk({32'h0, r}, 64'h0);
        sys(1'h1, WAHC_OP1_HYP, WAHC_OP2_CTRL, WAHC_EL2, 1'h0, 1'h0, '1, 2'h0, 64'h0);
        chk(ctrl_hyp, 64'h3333);
        sys(1'h0, WAHC_OP1_HYP, WAHC_OP2_CTRL, WAHC_EL3, 1'h0, 1'h0, '0, 2'h0,
            64'h3333);
        sys(1'h0, WAHC_OP1_HYP, WAHC_OP2_CTRL, WAHC_EL1, 1'h0, 1'h0, '0, 2'h1, 64'h0);
        sys(1'h1, WAHC_OP1_MON, WAHC_OP2_CTRL, WAHC_EL3, 1'h0, 1'h0, '1, 2'h0, 64'h0);
        chk(ctrl_mon, 64'h303);
        sys(1'h0, WAHC_OP1_MON, WAHC_OP2_CTRL, WAHC_EL3, 1'h0, 1'h0, '0, 2'h0,
            64'h303);
        sys(1'h0, WAHC_OP1_MON, WAHC_OP2_CTRL, WAHC_EL2, 1'h0, 1'h0, '0, 2'h1, 64'h0);
        walk(WAHC_RG_MON, 1'h0, 1'h0, 1'h0, 2'h3);
        sys(1'h1, WAHC_OP1_MON, WAHC_OP2_CTRL, WAHC_EL3, 1'h0, 1'h0, 64'h0201, 2'h0,
            64'h0);
        walk(WAHC_RG_MON, 1'h0, 1'h0, 1'h0, 2'h0);
        sys(1'h1, WAHC_OP1_HYP, WAHC_OP2_STAGE2, WAHC_EL2, 1'h0, 1'h0, '1, 2'h0,
            64'h0);
        chk(ctrl_s2, 64'h303);
        sys(1'h0, WAHC_OP1_HYP, WAHC_OP2_STAGE2, WAHC_EL3, 1'h0, 1'h0, '0, 2'h0,
            64'h303);
        sys(1'h0, WAHC_OP1_HYP, WAHC_OP2_STAGE2, WAHC_EL1, 1'h0, 1'h0, '0, 2'h1,
            64'h0);
        walk(WAHC_RG_GUEST_S2, 1'h0, 1'h1, 1'h1, 2'h3);
        walk(WAHC_RG_GUEST_S2, 1'h0, 1'h0, 1'h1, 2'h0);
        walk(WAHC_RG_GUEST_S2, 1'h0, 1'h1, 1'h0, 2'h0);
        sys(1'h1, WAHC_OP1_HYP, WAHC_OP2_STAGE2, WAHC_EL2, 1'h0, 1'h0, 64'h0301, 2'h0,
            64'h0);
        walk(WAHC_RG_GUEST_S2, 1'h0, 1'h1, 1'h1, 2'h1);
        sys(1'h1, WAHC_OP1_ALIAS, WAHC_OP2_CTRL, WAHC_EL2, 1'h0, 1'h0, '1, 2'h1,
            64'h0);
        chk(ctrl_guest, 64'h0);
        sys(1'h1, WAHC_OP1_ALIAS, WAHC_OP2_CTRL, WAHC_EL2, 1'h1, 1'h0, 64'h3120, 2'h0,
            64'h0);
        chk(ctrl_guest, 64'h3120);
        sys(1'h0, WAHC_OP1_GUEST, WAHC_OP2_CTRL, WAHC_EL1, 1'h0, 1'h0, '0, 2'h0,
            64'h3120);
        sys(1'h0, WAHC_OP1_ALIAS, WAHC_OP2_CTRL, WAHC_EL3, 1'h1, 1'h1, '0, 2'h2,
            64'h0);
        walk(WAHC_RG_GUEST_S1, 1'h1, 1'h0, 1'h1, hint_of(64'h3120, 1'h1));
        sys(1'h1, WAHC_OP1_GUEST, WAHC_OP2_CTRL, WAHC_EL2, 1'h1, 1'h1, 64'h1111, 2'h0,
            64'h0);
        chk(ctrl_hyp, 64'h1111);
        chk(ctrl_guest, 64'h3120);
        foreach (pats[i])
        begin
            sys(1'h1, WAHC_OP1_HYP, WAHC_OP2_CTRL, WAHC_EL2, 1'h0, 1'h0, pats[i], 2'h0,
                64'h0);
            walk(WAHC_RG_HYP, 1'h1, 1'h0, 1'h0, hint_of(pats[i], 1'h1));
            walk(WAHC_RG_HYP, 1'h0, 1'h0, 1'h0, hint_of(pats[i], 1'h0));
        end
        stop_test();
    end
endmodule : tb
